// File: core/disp_ctrl_pkg.sv
// constants shared by the display-control command interpreter
package disp_ctrl_pkg;
	// opcode patterns and the mask of bits that are fixed in each
	localparam logic [7:0] OP_BIAS      = 8'h81;
	localparam logic [7:0] OP_PARTIAL   = 8'h84;
	localparam logic [7:0] MK_PARTIAL   = 8'hfc;
	localparam logic [7:0] OP_STEP      = 8'h88;
	localparam logic [7:0] MK_STEP      = 8'hf8;
	localparam logic [7:0] OP_FIXED     = 8'h90;
	localparam logic [7:0] OP_LRATE     = 8'ha0;
	localparam logic [7:0] MK_LRATE     = 8'hfc;
	localparam logic [7:0] OP_ALLON     = 8'ha4;
	localparam logic [7:0] OP_INVERSE   = 8'ha6;
	localparam logic [7:0] MK_ONEBIT    = 8'hfe;
	localparam logic [7:0] OP_DISPEN    = 8'ha8;
	localparam logic [7:0] OP_MASK      = 8'hb0;
	localparam logic [7:0] OP_MAPPING   = 8'hc0;
	localparam logic [7:0] OP_PATTERN   = 8'hd0;
	localparam logic [7:0] OP_SYSRESET  = 8'he2;
	localparam logic [7:0] OP_TEST      = 8'he4;
	localparam logic [7:0] OP_ADVPROG   = 8'h30;
	localparam logic [7:0] OP_LASTROW   = 8'hf1;
	localparam logic [7:0] OP_BANDFIRST = 8'hf2;
	localparam logic [7:0] OP_BANDLAST  = 8'hf3;
	localparam logic [7:0] OP_WINBOUND  = 8'hf4;
	localparam logic [7:0] OP_WINEN     = 8'hf8;
	localparam logic [7:0] OP_COL_LO    = 8'h00;
	localparam logic [7:0] OP_COL_HI    = 8'h10;
	localparam logic [7:0] OP_ROW_LO    = 8'h60;
	localparam logic [7:0] OP_ROW_HI    = 8'h70;
	localparam logic [7:0] MK_NIBBLE    = 8'hf0;
	localparam logic [7:0] MK_TRIPLE    = 8'hf8;
	// pointer ranges; window bounds sit at these defaults
	localparam logic [6:0] COL_LAST     = 7'h61;
	localparam logic [6:0] ROW_LAST     = 7'h43;
	// reset values
	localparam logic [7:0] RST_BIAS     = 8'h00;
	localparam logic [2:0] RST_STEP     = 3'h1;
	localparam logic [1:0] RST_LRATE    = 2'h2;
	localparam logic [1:0] RST_SHADE    = 2'h3;
	localparam logic [6:0] RST_LASTROW  = 7'h43;
	localparam logic [6:0] RST_BANDLAST = 7'h43;
	// shade codes
	localparam logic [1:0] SHADE_ONOFF  = 2'h0;
	// multiplex rates at which line rate is scaled down
	localparam logic [7:0] MUX_HALF     = 8'h1c;
	localparam logic [7:0] MUX_THIRD    = 8'h10;
	// line rates in tenths of kilolines per second
	localparam logic [7:0] LR_SH0 = 8'h87;
	localparam logic [7:0] LR_SH1 = 8'h9b;
	localparam logic [7:0] LR_SH2 = 8'hb1;
	localparam logic [7:0] LR_SH3 = 8'hca;
	localparam logic [7:0] LR_OO0 = 8'h39;
	localparam logic [7:0] LR_OO1 = 8'h41;
	localparam logic [7:0] LR_OO2 = 8'h4a;
	localparam logic [7:0] LR_OO3 = 8'h55;
	// settle time of the bias supply after wake, in cycles
	localparam logic [2:0] POWER_SETTLE_CYC = 3'h4;
	localparam logic [5:0] SHADE_FULL = 6'h3f;
	typedef enum logic [2:0] {
		P_NONE, P_BIAS, P_FIXED, P_LASTROW, P_BANDFIRST, P_BANDLAST, P_SKIP
	} pend_e;
	typedef enum logic [1:0] {PW_SLEEP, PW_WAKE, PW_POWER, PW_DRIVE} pwr_e;
endpackage

// File: core/display_control_command_regs.sv
// command interpreter holding the display-control settings
// Function
// RULE1 - bias trim parameter byte loads all 8 bits, 0 to 255 valid
// RULE2 - partial field: 0X off, 10b on at full rate, 11b narrowed rate
// RULE3 - wrap off stops leading pointer; wrap on restarts it, steps other
// RULE4 - order bit picks column-first or row-first stepping
// RULE5 - row step sign picks +1 or -1, also on column wrap
// RULE6 - window enable changes nothing while bounds hold defaults
// RULE7 - fixed lines byte: upper nibble top pairs, lower nibble bottom
// RULE8 - frozen rows are twice the pairs; row mirror swaps top and bottom
// RULE9 - host keeps active band clear of frozen bands before icon enable
// RULE10 - shaded line rate codes give 13.5, 15.5, 17.7, 20.2 klps
// RULE11 - line rate scaled by half at mux 28, by third at mux 16
// RULE12 - on-off line rate codes give 5.7, 6.5, 7.4, 8.5 klps
// RULE13 - all-on forces every column output on, ram untouched
// RULE14 - inverse outputs bitwise inverse of ram data, ram untouched
// RULE15 - clearing display enable sleeps drivers, power and timing
// RULE16 - setting enable wakes, restores power, then enables drivers
// RULE17 - shade field: 00 on-off, 10 eight, 11 thirty-two; on-off uses msb; code gives 10 the same levels as 11
// RULE18 - colour block bits stop that colour being written to ram
// RULE19 - row mirror reverses row mapping at once, ram untouched
// RULE20 - column mirror uses 97 minus column pointer for host access
// RULE21 - icon bit shows frozen bands during partial display
// RULE22 - pattern bit swaps red and blue; default order blue, green, red
// RULE23 - column pointer counts rgb triplets from 0 to 97
// RULE24 - next command byte after a double-byte opcode is its parameter
`timescale 1ns/100ps
`default_nettype none
module display_control_command_regs
	import disp_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// host command byte, command mode when cd is low
	input  wire logic        host_valid,
	input  wire logic        host_cd,
	input  wire logic [7:0]  host_byte,
	// one pulse per rgb triplet written to or read from ram
	input  wire logic        data_step,
	input  wire logic        data_write,
	// pixel fetched for the current column triplet {r4,g5,b4}
	input  wire logic [12:0] pixel_rgb,
	// settings
	output logic      [7:0]  bias_trim_level,
	output logic      [9:0]  partial_mode_select,
	output logic      [2:0]  ram_step_ctrl,
	output logic      [7:0]  frozen_band_sizes,
	output logic      [4:0]  drive_shade_ctrl,
	output logic      [2:0]  colour_write_block,
	output logic      [6:0]  last_scan_row,
	output logic      [6:0]  active_band_first,
	output logic      [6:0]  active_band_last,
	output logic             window_enable,
	// address pointers
	output logic      [6:0]  column_pointer,
	output logic      [6:0]  row_pointer,
	output logic      [6:0]  ram_column,
	// ram write enables per colour
	output logic             ram_wr_red,
	output logic             ram_wr_green,
	output logic             ram_wr_blue,
	// derived timing
	output logic      [7:0]  mux_rate,
	output logic      [7:0]  line_rate_tenths,
	output logic      [1:0]  line_rate_div,
	output logic      [4:0]  frozen_top_rows,
	output logic      [4:0]  frozen_bottom_rows,
	output logic             icon_visible,
	// power sequencing
	output logic             timing_run,
	output logic             power_run,
	output logic             drivers_run,
	// shade levels for the three column electrodes of a triplet
	output logic      [17:0] column_driver_output
);
	import disp_ctrl_pkg::*;

	typedef struct packed {
		pend_e       pend;
		logic [7:0]  bias;
		logic [1:0]  pmode;
		logic [2:0]  step;
		logic        win_en;
		logic [3:0]  top_pairs;
		logic [3:0]  bot_pairs;
		logic [1:0]  lrate;
		logic        all_on;
		logic        inverse;
		logic        disp_en;
		logic [1:0]  shade;
		logic [2:0]  mask;
		logic        rmir;
		logic        cmir;
		logic        icon;
		logic        pattern;
		logic [6:0]  lastrow;
		logic [6:0]  bfirst;
		logic [6:0]  blast;
		logic [6:0]  ca;
		logic [6:0]  ra;
		logic [6:0]  ramcol;
		logic [7:0]  mux;
		logic [7:0]  lr;
		logic [1:0]  lrdiv;
		logic [4:0]  ftop;
		logic [4:0]  fbot;
		pwr_e        pwr;
		logic [2:0]  pcnt;
		logic [17:0] cols;
	} state_s;

	state_s s;
	state_s next_s;

	// fixed-bit match of a command byte
	function automatic logic op_is(input logic [7:0] b,
		input logic [7:0] op, input logic [7:0] mk);
		op_is = ((b & mk) == op);
	endfunction

	// one row step with wrap at the ram ends
	function automatic logic [6:0] row_step(input logic [6:0] r,
		input logic neg);
		if (neg) begin // [RULE5]
			row_step = (r == 7'h00) ? ROW_LAST : r - 7'h01;
		end else begin
			row_step = (r == ROW_LAST) ? 7'h00 : r + 7'h01;
		end
	endfunction

	// base line rate before mux scaling
	function automatic logic [7:0] base_rate(input logic [1:0] code,
		input logic onoff);
		logic [7:0] r;
		r = LR_SH0;
		case ({onoff, code})
			3'h0: r = LR_SH0; // [RULE10]
			3'h1: r = LR_SH1;
			3'h2: r = LR_SH2;
			3'h3: r = LR_SH3;
			3'h4: r = LR_OO0; // [RULE12]
			3'h5: r = LR_OO1;
			3'h6: r = LR_OO2;
			default: r = LR_OO3;
		endcase
		base_rate = r;
	endfunction

	// reset image of every register
	function automatic state_s reset_state();
		state_s r;
		r         = '0;
		r.pend    = P_NONE;
		r.bias    = RST_BIAS;
		r.step    = RST_STEP;
		r.lrate   = RST_LRATE;
		r.shade   = RST_SHADE;
		r.lastrow = RST_LASTROW;
		r.blast   = RST_BANDLAST;
		r.pwr     = PW_SLEEP;
		reset_state = r;
	endfunction

	logic       cmd;
	logic       onoff;
	logic       col_end;
	logic       row_end;
	logic [4:0] dbl_top;
	logic [4:0] dbl_bot;
	logic [5:0] lvl_r;
	logic [5:0] lvl_g;
	logic [5:0] lvl_b;
	logic [12:0] pix;

	// next-state logic: commands, pointers, derived values, power
	always_comb begin
		next_s  = s;
		cmd     = host_valid && !host_cd;
		onoff   = (s.shade == SHADE_ONOFF);
		col_end = (s.ca == COL_LAST);
		row_end = s.step[2] ? (s.ra == 7'h00) : (s.ra == ROW_LAST);
		dbl_top = {s.top_pairs, 1'b0};
		dbl_bot = {s.bot_pairs, 1'b0};
		lvl_r   = '0;
		lvl_g   = '0;
		lvl_b   = '0;
		// inverse acts on the stored data, not on the padded level
		pix     = s.inverse ? ~pixel_rgb : pixel_rgb; // [RULE14]

		// command decode; a pending parameter takes the byte first
		if (cmd && s.pend != P_NONE) begin
			case (s.pend) // [RULE24]
				P_BIAS:      next_s.bias = host_byte; // [RULE1]
				P_FIXED: begin
					next_s.top_pairs = host_byte[7:4]; // [RULE7]
					next_s.bot_pairs = host_byte[3:0];
				end
				P_LASTROW:   next_s.lastrow = host_byte[6:0];
				P_BANDFIRST: next_s.bfirst  = host_byte[6:0];
				P_BANDLAST:  next_s.blast   = host_byte[6:0];
				default:     next_s.pend    = P_NONE;
			endcase
			next_s.pend = P_NONE;
		end else if (cmd) begin
			if (host_byte == OP_SYSRESET) begin
				next_s = reset_state();
			end else if (host_byte == OP_BIAS) begin
				next_s.pend = P_BIAS;
			end else if (host_byte == OP_FIXED) begin
				next_s.pend = P_FIXED;
			end else if (host_byte == OP_LASTROW) begin
				next_s.pend = P_LASTROW;
			end else if (host_byte == OP_BANDFIRST) begin
				next_s.pend = P_BANDFIRST;
			end else if (host_byte == OP_BANDLAST) begin
				next_s.pend = P_BANDLAST;
			end else if (op_is(host_byte, OP_WINBOUND, 8'hfc) ||
				op_is(host_byte, OP_TEST, 8'hfc) ||
				op_is(host_byte, OP_ADVPROG, 8'hfc)) begin
				// window bounds stay at defaults; parameter is swallowed
				next_s.pend = P_SKIP;
			end else if (op_is(host_byte, OP_WINEN, MK_ONEBIT)) begin
				next_s.win_en = host_byte[0]; // [RULE6]
			end else if (op_is(host_byte, OP_PARTIAL, MK_PARTIAL)) begin
				next_s.pmode = host_byte[1:0];
			end else if (op_is(host_byte, OP_STEP, MK_STEP)) begin
				next_s.step = host_byte[2:0];
			end else if (op_is(host_byte, OP_LRATE, MK_LRATE)) begin
				next_s.lrate = host_byte[1:0];
			end else if (op_is(host_byte, OP_ALLON, MK_ONEBIT)) begin
				next_s.all_on = host_byte[0];
			end else if (op_is(host_byte, OP_INVERSE, MK_ONEBIT)) begin
				next_s.inverse = host_byte[0];
			end else if (op_is(host_byte, OP_DISPEN, MK_STEP)) begin
				next_s.shade   = host_byte[2:1]; // [RULE17]
				next_s.disp_en = host_byte[0];
			end else if (op_is(host_byte, OP_MASK, MK_STEP)) begin
				next_s.mask = host_byte[2:0];
			end else if (op_is(host_byte, OP_MAPPING, MK_STEP)) begin
				next_s.rmir = host_byte[2];
				next_s.cmir = host_byte[1];
				next_s.icon = host_byte[0];
			end else if (op_is(host_byte, OP_PATTERN, MK_ONEBIT)) begin
				next_s.pattern = host_byte[0];
			end else if (op_is(host_byte, OP_COL_LO, MK_NIBBLE)) begin
				next_s.ca[3:0] = host_byte[3:0];
			end else if (op_is(host_byte, OP_COL_HI, MK_TRIPLE)) begin
				next_s.ca[6:4] = host_byte[2:0];
			end else if (op_is(host_byte, OP_ROW_LO, MK_NIBBLE)) begin
				next_s.ra[3:0] = host_byte[3:0];
			end else if (op_is(host_byte, OP_ROW_HI, MK_TRIPLE)) begin
				next_s.ra[6:4] = host_byte[2:0];
			end
		end else if (data_step) begin
			// pointer stepping; bounds are the ram ends, so the window
			// enable has no say while its bounds hold their defaults
			if (!s.step[1]) begin // [RULE4] [RULE6]
				if (!col_end) begin
					next_s.ca = s.ca + 7'h01; // [RULE23]
				end else if (s.step[0]) begin // [RULE3]
					next_s.ca = 7'h00;
					next_s.ra = row_step(s.ra, s.step[2]); // [RULE5]
				end
			end else begin
				if (!row_end) begin
					next_s.ra = row_step(s.ra, s.step[2]); // [RULE4]
				end else if (s.step[0]) begin // [RULE3]
					next_s.ra = s.step[2] ? ROW_LAST : 7'h00;
					next_s.ca = col_end ? 7'h00 : s.ca + 7'h01;
				end
			end
		end

		// host ram column, mirrored on request
		next_s.ramcol = s.cmir ? COL_LAST - s.ca : s.ca; // [RULE20]

		// multiplex rate from the partial mode
		if (s.pmode == 2'h3) begin // [RULE2]
			next_s.mux = {1'b0, s.blast - s.bfirst} + 8'h01 +
				(s.icon ? {2'b00, 6'(dbl_top) + 6'(dbl_bot)} : 8'h00);
		end else begin
			next_s.mux = {1'b0, s.lastrow} + 8'h01;
		end

		// line rate and its automatic scaling
		next_s.lr = base_rate(s.lrate, onoff);
		if (s.mux == MUX_HALF) begin // [RULE11]
			next_s.lrdiv = 2'h2;
		end else if (s.mux == MUX_THIRD) begin
			next_s.lrdiv = 2'h3;
		end else begin
			next_s.lrdiv = 2'h1;
		end

		// frozen bands, swapped by the row mirror
		next_s.ftop = s.rmir ? dbl_bot : dbl_top; // [RULE8]
		next_s.fbot = s.rmir ? dbl_top : dbl_bot;

		// power sequence: wake, settle supply, then drivers
		case (s.pwr)
			PW_SLEEP: begin
				if (s.disp_en) begin
					next_s.pwr = PW_WAKE; // [RULE16]
				end
			end
			PW_WAKE: begin
				next_s.pwr  = PW_POWER;
				next_s.pcnt = POWER_SETTLE_CYC;
			end
			PW_POWER: begin
				next_s.pcnt = s.pcnt - 3'h1;
				if (s.pcnt == 3'h1) begin
					next_s.pwr = PW_DRIVE;
				end
			end
			default: next_s.pwr = PW_DRIVE;
		endcase
		if (!s.disp_en) begin
			next_s.pwr = PW_SLEEP; // [RULE15]
		end

		// column levels; on-off follows the colour msb only
		if (onoff) begin // [RULE17]
			lvl_r = pix[12] ? SHADE_FULL : 6'h00;
			lvl_g = pix[8] ? SHADE_FULL : 6'h00;
			lvl_b = pix[3] ? SHADE_FULL : 6'h00;
		end else begin
			lvl_r = {pix[12:9], 2'b00};
			lvl_g = {pix[8:4], 1'b0};
			lvl_b = {pix[3:0], 2'b00};
		end
		if (s.all_on) begin // [RULE13]
			lvl_r = SHADE_FULL;
			lvl_g = SHADE_FULL;
			lvl_b = SHADE_FULL;
		end
		// first electrode of a triplet is blue unless swapped
		if (s.pwr != PW_DRIVE) begin
			next_s.cols = '0;
		end else if (s.pattern) begin // [RULE22]
			next_s.cols = {lvl_r, lvl_g, lvl_b};
		end else begin
			next_s.cols = {lvl_b, lvl_g, lvl_r};
		end
	end

	// single state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= reset_state();
		end else begin
			s <= next_s;
		end
	end

	// outputs; ram writes are gated only, stored data never rewritten
	assign bias_trim_level      = s.bias;
	assign partial_mode_select  = {s.pmode, 2'b00, s.pattern, s.lrate,
		s.rmir, s.cmir, s.icon};
	assign ram_step_ctrl        = s.step;
	assign frozen_band_sizes    = {s.top_pairs, s.bot_pairs};
	assign drive_shade_ctrl     = {s.shade, s.disp_en, s.all_on, s.inverse};
	assign colour_write_block   = s.mask;
	assign last_scan_row        = s.lastrow;
	assign active_band_first    = s.bfirst;
	assign active_band_last     = s.blast;
	assign window_enable        = s.win_en;
	assign column_pointer       = s.ca;
	assign row_pointer          = s.ra;
	assign ram_column           = s.ramcol;
	assign ram_wr_red   = data_write && !s.mask[2]; // [RULE18]
	assign ram_wr_green = data_write && !s.mask[1];
	assign ram_wr_blue  = data_write && !s.mask[0];
	assign mux_rate             = s.mux;
	assign line_rate_tenths     = s.lr;
	assign line_rate_div        = s.lrdiv;
	assign frozen_top_rows      = s.ftop;
	assign frozen_bottom_rows   = s.fbot;
	// row mirror acts on the scan mapping directly, so no ram rewrite
	assign icon_visible = s.pmode[1] && s.icon; // [RULE21] [RULE19] [RULE9]
	assign timing_run   = (s.pwr != PW_SLEEP);
	assign power_run    = (s.pwr == PW_POWER) || (s.pwr == PW_DRIVE);
	assign drivers_run  = (s.pwr == PW_DRIVE);
	assign column_driver_output = s.cols;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_BIAS_LOAD: assert property ( // [RULE1]
		host_valid && !host_cd && s.pend == P_BIAS
		|=> bias_trim_level == $past(host_byte))
		else $error("bias parameter not loaded");
	AST_FIXED_SPLIT: assert property ( // [RULE7]
		host_valid && !host_cd && s.pend == P_FIXED
		|=> frozen_band_sizes == $past(host_byte))
		else $error("fixed lines parameter not split");
	AST_STOP_AT_END: assert property ( // [RULE3]
		data_step && !(host_valid && !host_cd) && s.step[1:0] == 2'b00
		&& s.ca == COL_LAST |=> column_pointer == COL_LAST)
		else $error("column pointer moved past its end");
	AST_COL_WRAP: assert property ( // [RULE5]
		data_step && !(host_valid && !host_cd) && s.step == 3'b001
		&& s.ca == COL_LAST && s.ra != ROW_LAST
		|=> column_pointer == 7'h00 && row_pointer == $past(s.ra) + 7'h01)
		else $error("column wrap did not step row");
	AST_SLEEP: assert property ( // [RULE15]
		!s.disp_en |=> !timing_run && !power_run && !drivers_run)
		else $error("sleep did not halt");
	AST_WAKE_ORDER: assert property ( // [RULE16]
		$rose(drivers_run) |-> $past(power_run, 4) && $past(timing_run, 5))
		else $error("drivers before power");
	AST_MASK_RED: assert property ( // [RULE18]
		s.mask[2] |-> !ram_wr_red)
		else $error("masked red written");
	AST_FULL_MUX: assert property ( // [RULE2]
		s.pmode != 2'h3 ##1 s.pmode != 2'h3 && $stable(s.lastrow)
		|-> mux_rate == {1'b0, s.lastrow} + 8'h01)
		else $error("mux rate not last row plus one");
	AST_HALF_RATE: assert property ( // [RULE11]
		mux_rate == MUX_HALF |=> line_rate_div == 2'h2)
		else $error("line rate not halved");
	AST_MIRROR_SWAP: assert property ( // [RULE8]
		s.rmir && $stable(s.rmir) && $stable(frozen_band_sizes)
		|-> frozen_top_rows == {s.bot_pairs, 1'b0})
		else $error("frozen bands not swapped");
	AST_ALL_ON: assert property ( // [RULE13]
		s.all_on && drivers_run ##1 s.all_on && drivers_run
		|-> column_driver_output == {3{SHADE_FULL}})
		else $error("all-on not full");
endmodule // display_control_command_regs
`default_nettype wire

// File: verif/host_model.sv
// host processor model that writes command bytes to the interpreter
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// clock
	input  wire logic       clk,
	// command bus
	output logic            host_valid,
	output logic            host_cd,
	output logic [7:0]      host_byte
);
	// bus idles with cd high so nothing is taken as a command
	initial begin
		host_valid = 1'b0;
		host_cd    = 1'b1;
		host_byte  = 8'h00;
	end
	// one byte per edge, launched just after it; back to back is legal
	task automatic put(input logic [7:0] b);
		@(posedge clk);
		#1;
		host_valid = 1'b1;
		host_cd    = 1'b0;
		host_byte  = b;
	endtask
	// released bus shows the inverted byte so a stale value never matches
	task automatic idle();
		@(posedge clk);
		#1;
		host_valid = 1'b0;
		host_cd    = 1'b1;
		host_byte  = ~host_byte;
	endtask
endmodule // host_model
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the display-control command interpreter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import disp_ctrl_pkg::*;
	localparam logic [7:0] rates [8] = '{LR_SH0, LR_SH1, LR_SH2, LR_SH3,
		LR_OO0, LR_OO1, LR_OO2, LR_OO3};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        data_step = 1'b0;
	logic        data_write = 1'b0;
	logic [12:0] pixel_rgb = 13'h0000;
	wire logic   host_valid, host_cd;
	wire logic [7:0] host_byte;
	logic [7:0]  bias_trim_level, frozen_band_sizes, mux_rate;
	logic [7:0]  line_rate_tenths, v, tr, pr, dr, rnd = 8'h17;
	logic [9:0]  partial_mode_select;
	logic [2:0]  ram_step_ctrl, colour_write_block, ctl;
	logic [4:0]  drive_shade_ctrl, frozen_top_rows, frozen_bottom_rows;
	logic [6:0]  last_scan_row, active_band_first, active_band_last;
	logic [6:0]  column_pointer, row_pointer, ram_column, ca, ra;
	logic        window_enable, ram_wr_red, ram_wr_green, ram_wr_blue;
	logic        icon_visible, timing_run, power_run, drivers_run;
	logic [1:0]  line_rate_div;
	logic [17:0] column_driver_output;
	int          mismatches = 0;
	int          checks_done = 0;
	int          cycles = 0;

	display_control_command_regs uut (.clk(clk), .rst(rst),
		.host_valid(host_valid), .host_cd(host_cd), .host_byte(host_byte),
		.data_step(data_step), .data_write(data_write),
		.pixel_rgb(pixel_rgb), .bias_trim_level(bias_trim_level),
		.partial_mode_select(partial_mode_select),
		.ram_step_ctrl(ram_step_ctrl), .frozen_band_sizes(frozen_band_sizes),
		.drive_shade_ctrl(drive_shade_ctrl),
		.colour_write_block(colour_write_block),
		.last_scan_row(last_scan_row), .active_band_first(active_band_first),
		.active_band_last(active_band_last), .window_enable(window_enable),
		.column_pointer(column_pointer), .row_pointer(row_pointer),
		.ram_column(ram_column), .ram_wr_red(ram_wr_red),
		.ram_wr_green(ram_wr_green), .ram_wr_blue(ram_wr_blue),
		.mux_rate(mux_rate), .line_rate_tenths(line_rate_tenths),
		.line_rate_div(line_rate_div), .frozen_top_rows(frozen_top_rows),
		.frozen_bottom_rows(frozen_bottom_rows), .icon_visible(icon_visible),
		.timing_run(timing_run), .power_run(power_run),
		.drivers_run(drivers_run),
		.column_driver_output(column_driver_output));
	host_model host (.clk(clk), .host_valid(host_valid), .host_cd(host_cd),
		.host_byte(host_byte));

	// 200 mhz clock
	always #2.5 clk = ~clk;

	// a hang ends the run as a failure
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp,
		input string what);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	// waits long enough for derived values, which lag up to three edges
	task automatic cmd(input logic [7:0] op);
		host.put(op);
		host.idle();
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic cmd2(input logic [7:0] op, input logic [7:0] prm);
		host.put(op);
		cmd(prm);
	endtask

	task automatic step();
		data_step = 1'b1;
		@(posedge clk);
		#1;
		data_step = 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// expected pointers after one step under the given step control
	function automatic logic [13:0] next_ptr(input logic [6:0] c,
		input logic [6:0] r, input logic [2:0] k);
		logic [6:0] rs;
		rs = k[2] ? ((r == 7'h00) ? ROW_LAST : r - 7'h01)
			: ((r == ROW_LAST) ? 7'h00 : r + 7'h01);
		if (!k[1]) begin
			if (c != COL_LAST) return {c + 7'h01, r};
			return k[0] ? {7'h00, rs} : {c, r};
		end
		if (r != (k[2] ? 7'h00 : ROW_LAST)) return {c, rs};
		return k[0] ? {c + 7'h01, k[2] ? ROW_LAST : 7'h00} : {c, r};
	endfunction

	// expected three electrode levels of one triplet
	function automatic logic [17:0] col_exp(input logic [12:0] px,
		input logic inv, input logic ao, input logic pat, input logic oo);
		logic [12:0] d;
		logic [5:0]  r, g, b;
		d = inv ? ~px : px;
		r = oo ? {6{d[12]}} : {d[12:9], 2'b00};
		g = oo ? {6{d[8]}} : {d[8:4], 1'b0};
		b = oo ? {6{d[3]}} : {d[3:0], 2'b00};
		if (ao) return {3{SHADE_FULL}};
		return pat ? {r, g, b} : {b, g, r};
	endfunction

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({bias_trim_level, partial_mode_select}, 24'h000010, "rst a");
		chk({ram_step_ctrl, frozen_band_sizes, drive_shade_ctrl},
			{3'h1, 8'h00, 5'h18}, "rst b");
		chk({mux_rate, line_rate_tenths, line_rate_div}, 24'h0112c5, "rst c");
		chk({last_scan_row, active_band_last}, 24'h0021c3, "rst d");
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd;
			cmd2(8'h81, v);
			chk(bias_trim_level, v, "bias");
		end
		cmd2(8'hf1, 8'h28);
		cmd2(8'hf2, 8'h14);
		cmd2(8'hf3, 8'h1e);
		cmd2(8'h90, 8'h32);
		chk({frozen_top_rows, frozen_bottom_rows}, 24'h0000c4, "fz");
		chk({active_band_first, active_band_last, last_scan_row},
			{7'h14, 7'h1e, 7'h28}, "band");
		cmd(8'hc1); // band 20..30 clears both frozen bands
		for (int p = 0; p < 4; p++) begin
			cmd(8'h84 | 8'(p));
			chk({partial_mode_select[9:8], icon_visible,
				(p == 3) ? 8'h15 : 8'h29}, {2'(p), p > 1, mux_rate}, "pm");
		end
		cmd(8'hc5);
		chk({partial_mode_select[2], frozen_top_rows, frozen_bottom_rows},
			{1'b1, 5'h04, 5'h06}, "mirror");
		cmd(8'hc0);
		cmd2(8'hf2, 8'h00);
		cmd2(8'hf3, 8'h1b);
		chk({mux_rate, line_rate_div}, {8'h1c, 2'h2}, "half");
		cmd2(8'hf3, 8'h0f);
		chk({mux_rate, line_rate_div}, {8'h10, 2'h3}, "third");
		for (int s = 0; s < 8; s++) begin
			cmd(s > 3 ? 8'ha8 : 8'hae);
			cmd(8'ha0 | 8'(s % 4));
			chk(line_rate_tenths, rates[s], "rate");
		end
		cmd(8'hf9); // window enabled with bounds left at defaults
		chk(window_enable, 1'b1, "win");
		for (int k = 0; k < 8; k++) begin
			ctl = 3'(k);
			ca = ctl[1] ? 7'h0a : 7'h5f;
			ra = ctl[1] ? (ctl[2] ? 7'h02 : 7'h41)
				: (ctl[2] ? 7'h00 : ROW_LAST);
			cmd(8'h88 | {5'h00, ctl});
			host.put({4'h0, ca[3:0]});
			host.put({5'h02, ca[6:4]});
			host.put({4'h6, ra[3:0]});
			host.put({5'h0e, ra[6:4]});
			host.idle();
			for (int n = 0; n < 4; n++) begin
				{ca, ra} = next_ptr(ca, ra, ctl);
				step();
				chk({column_pointer, row_pointer}, {ca, ra}, "ptr");
			end
		end
		cmd(8'hc2);
		{ca, ra} = next_ptr(ca, ra, ctl);
		step();
		chk(ram_column, COL_LAST - ca, "col mirror");
		data_write = 1'b1;
		for (int m = 0; m < 8; m++) begin
			cmd(8'hb0 | 8'(m));
			chk({colour_write_block, ram_wr_red, ram_wr_green, ram_wr_blue},
				{3'(m), ~3'(m)}, "mask");
		end
		data_write = 1'b0;
		host.put(8'haf);
		host.idle();
		tr = 8'h00;
		pr = 8'h00;
		dr = 8'h00;
		for (int i = 1; i < 10; i++) begin
			@(posedge clk);
			#1;
			if (timing_run === 1'b1 && tr == 8'h00) tr = 8'(i);
			if (power_run === 1'b1 && pr == 8'h00) pr = 8'(i);
			if (drivers_run === 1'b1 && dr == 8'h00) dr = 8'(i);
		end
		chk({tr, pr, dr}, 24'h010206, "wake");
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			pixel_rgb = (i == 0) ? 13'h1fff : {rnd[4:0], lfsr(rnd)};
			cmd(rnd[0] ? 8'ha9 : 8'haf);
			cmd(8'ha6 | {7'h00, rnd[1]});
			cmd(8'ha4 | {7'h00, i == 3});
			cmd(8'hd0 | {7'h00, rnd[2]});
			chk(column_driver_output, col_exp(pixel_rgb, rnd[1], i == 3,
				rnd[2], rnd[0]), "column");
		end
		host.put(8'hae);
		host.idle();
		repeat (2) @(posedge clk);
		#1;
		chk({timing_run, power_run, drivers_run}, 24'h0, "sleep");
		cmd(8'he2);
		chk({bias_trim_level, ram_step_ctrl}, {8'h00, RST_STEP}, "sysrst");
		chk(column_driver_output, 24'h0, "dark");
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
